/* File: charge_setpoint_registers.sv */
// Purpose: Charge-current and charge-voltage setpoints with precharge clamps.
// Assumes: Byte writes and reads come from serial-port logic on clk_sys_i.
// Notes:   Pins pass two flops; battery voltage comes from on-clock logic.
`timescale 1ns/100ps
`default_nettype none
module charge_setpoint_registers (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic        reg_wr_en_i,
	input  wire logic        reg_rd_en_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	output var  logic [7:0]  reg_rdata_o,
	input  wire logic        adapter_good_flag_i,
	input  wire logic        input_overvoltage_i,
	input  wire logic        cell_count_presence_pin_i,
	input  wire logic [1:0]  cell_count_sel_i,
	input  wire logic        precharge_i,
	input  wire logic [15:0] battery_mv_i,
	output var  logic [12:0] charge_current_setpoint_o,
	output var  logic [15:0] charge_voltage_limit_o,
	output var  logic        charge_enable_o,
	output var  logic [12:0] current_limit_ma_o,
	output var  logic        battery_switch_linear_o,
	output var  logic        regulate_min_sys_o
);

	logic [3:0]  pins_s;
	logic        agf_s;
	logic        ov_s;
	logic        pres_s;
	logic [1:0]  sel_s;
	logic        ichg_valid;
	logic        vlim_valid;
	logic [15:0] ichg_word;
	logic [15:0] vlim_word;
	logic        agf_fall;
	logic        pres_fall;
	logic        ichg_ok;
	logic [6:0]  ichg_field;
	logic [15:0] vlim_val;
	logic        vlim_ok;
	logic        vlim_zero;
	logic        vlim_in_range;
	logic        single;
	logic        lowv1;
	logic        midv1;
	logic        pre_multi;
	logic [12:0] setpoint_ma;

	logic        init_q, init_d;
	logic [1:0]  cells_q, cells_d;
	logic        agf_prev_q, agf_prev_d;
	logic        pres_prev_q, pres_prev_d;
	logic [6:0]  ichg_q, ichg_d;
	logic [15:0] vlim_q, vlim_d;
	logic        lin_q, lin_d;
	logic [7:0]  rdata_q, rdata_d;
	logic        en_q, en_d;
	logic [12:0] lim_q, lim_d;
	logic        swl_q, swl_d;
	logic        rms_q, rms_d;

	// Pins cross into the clock domain before anything looks at them.
	level_sync #(
		.W(4)
	) u_pin_sync (
		.clk_sys_i(clk_sys_i),
		.async_i  ({cell_count_sel_i, cell_count_presence_pin_i, adapter_good_flag_i}),
		.sync_o   (pins_s)
	);

	assign agf_s  = pins_s[0];
	assign pres_s = pins_s[1];
	assign sel_s  = pins_s[3:2];

	// Overvoltage is a separate pin and gets its own pair of flops.
	level_sync #(
		.W(1)
	) u_ov_sync (
		.clk_sys_i(clk_sys_i),
		.async_i  (input_overvoltage_i),
		.sync_o   (ov_s)
	);

	// Each 16-bit setpoint is judged only once both of its bytes are in.
	byte_pair_latch u_ichg_pair (
		.clk_sys_i   (clk_sys_i),
		.rst_n_i     (rst_n_i),
		.lo_wr_i     (reg_wr_en_i && reg_addr_i == charge_setpoint_pkg::ADDR_ICHG_LO),
		.hi_wr_i     (reg_wr_en_i && reg_addr_i == charge_setpoint_pkg::ADDR_ICHG_HI),
		.wdata_i     (reg_wdata_i),
		.word_o      (ichg_word),
		.word_valid_o(ichg_valid)
	);

	// The voltage pair is assembled the same way.
	byte_pair_latch u_vlim_pair (
		.clk_sys_i   (clk_sys_i),
		.rst_n_i     (rst_n_i),
		.lo_wr_i     (reg_wr_en_i && reg_addr_i == charge_setpoint_pkg::ADDR_VLIM_LO),
		.hi_wr_i     (reg_wr_en_i && reg_addr_i == charge_setpoint_pkg::ADDR_VLIM_HI),
		.wdata_i     (reg_wdata_i),
		.word_o      (vlim_word),
		.word_valid_o(vlim_valid)
	);

	// Decode the assembled words and the pin events.
	always_comb begin
		agf_fall  = agf_prev_q && !agf_s;
		pres_fall = pres_prev_q && !pres_s;
		ichg_ok   = (ichg_word[15:8] & charge_setpoint_pkg::ICHG_HI_RSVD) == 8'h00;
		ichg_field = ichg_word[12:6];
		vlim_val  = vlim_word & charge_setpoint_pkg::VLIM_FIELD;
		vlim_ok   = (vlim_word & charge_setpoint_pkg::VLIM_RSVD_HI) == 16'h0000;
		vlim_zero = vlim_ok && vlim_val == 16'h0000;
		vlim_in_range = vlim_val >= charge_setpoint_pkg::VLIM_MIN_MV &&
			vlim_val <= charge_setpoint_pkg::VLIM_MAX_MV;
	end

	// Setpoint next values. Only the adapter, input-overvoltage, presence and cell-select pins reach here;
	// overcurrent, thermal, system overvoltage and latch-off never do.
	always_comb begin
		init_d      = 1'b1;
		cells_d     = cells_q;
		agf_prev_d  = agf_s;
		pres_prev_d = pres_s;
		ichg_d      = ichg_q;
		vlim_d      = vlim_q;
		lin_d       = lin_q;
		if (!init_q) begin
			// Strap is caught on the first edge after release.
			cells_d = sel_s;
			vlim_d  = charge_setpoint_pkg::cell_default_mv(sel_s);
		end else if (vlim_valid && vlim_ok) begin
			if (vlim_zero) begin
				vlim_d = charge_setpoint_pkg::cell_default_mv(cells_q);
			end else if (vlim_in_range) begin
				vlim_d = vlim_val;
			end
		end
		if (ichg_valid && ichg_ok) begin
			ichg_d = ichg_field;
		end
		if (init_q && vlim_valid && vlim_zero) begin
			ichg_d = charge_setpoint_pkg::ICHG_RST;
		end
		// Clears win over a write landing in the same cycle: removal is final.
		if (agf_fall && !ov_s) begin
			ichg_d = charge_setpoint_pkg::ICHG_RST;
		end
		if (pres_fall) begin
			ichg_d = charge_setpoint_pkg::ICHG_RST;
		end
		if (reg_wr_en_i && reg_addr_i == charge_setpoint_pkg::ADDR_OPTION) begin
			lin_d = reg_wdata_i[charge_setpoint_pkg::LINEAR_BIT];
		end
	end

	// Setpoint registers.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			init_q      <= 1'b0;
			cells_q     <= charge_setpoint_pkg::CELL_1S;
			agf_prev_q  <= 1'b0;
			pres_prev_q <= 1'b0;
			ichg_q      <= charge_setpoint_pkg::ICHG_RST;
			vlim_q      <= charge_setpoint_pkg::VLIM_RST;
			lin_q       <= charge_setpoint_pkg::LINEAR_RST;
		end else begin
			init_q      <= init_d;
			cells_q     <= cells_d;
			agf_prev_q  <= agf_prev_d;
			pres_prev_q <= pres_prev_d;
			ichg_q      <= ichg_d;
			vlim_q      <= vlim_d;
			lin_q       <= lin_d;
		end
	end

	// Read mux; unused bits and unmapped addresses read zero.
	always_comb begin
		rdata_d = rdata_q;
		if (reg_rd_en_i) begin
			unique case (reg_addr_i)
				charge_setpoint_pkg::ADDR_OPTION:  rdata_d = {5'h00, lin_q, 2'h0};
				charge_setpoint_pkg::ADDR_ICHG_LO: rdata_d = {ichg_q[1:0], 6'h00};
				charge_setpoint_pkg::ADDR_ICHG_HI: rdata_d = {3'h0, ichg_q[6:2]};
				charge_setpoint_pkg::ADDR_VLIM_LO: rdata_d = vlim_q[7:0];
				charge_setpoint_pkg::ADDR_VLIM_HI: rdata_d = vlim_q[15:8];
				default:                           rdata_d = 8'h00;
			endcase
		end
	end

	// Charge control: clamps only ever lower the programmed current.
	always_comb begin
		setpoint_ma = {ichg_q, 6'h00};
		single    = cells_q == charge_setpoint_pkg::CELL_1S;
		lowv1     = single && battery_mv_i < charge_setpoint_pkg::FAST_ENTRY_MV;
		midv1     = single && !lowv1 &&
			battery_mv_i < charge_setpoint_pkg::LDO_EXIT_MV;
		pre_multi = !single && precharge_i;
		en_d  = agf_s && ichg_q != 7'h00;
		lim_d = setpoint_ma;
		if ((lowv1 || pre_multi) && setpoint_ma > charge_setpoint_pkg::PRECHG_CLAMP_MA) begin
			lim_d = charge_setpoint_pkg::PRECHG_CLAMP_MA;
		end
		if (midv1 && setpoint_ma > charge_setpoint_pkg::LOWV_CLAMP_MA) begin
			lim_d = charge_setpoint_pkg::LOWV_CLAMP_MA;
		end
		swl_d = ((lowv1 || pre_multi) && lin_q) || midv1;
		rms_d = pre_multi;
	end

	// Output registers.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rdata_q <= 8'h00;
			en_q    <= 1'b0;
			lim_q   <= 13'h0000;
			swl_q   <= 1'b0;
			rms_q   <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			en_q    <= en_d;
			lim_q   <= lim_d;
			swl_q   <= swl_d;
			rms_q   <= rms_d;
		end
	end

	assign reg_rdata_o               = rdata_q;
	assign charge_current_setpoint_o = {ichg_q, 6'h00};
	assign charge_voltage_limit_o    = vlim_q;
	assign charge_enable_o           = en_q;
	assign current_limit_ma_o        = lim_q;
	assign battery_switch_linear_o   = swl_q;
	assign regulate_min_sys_o        = rms_q;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	AST_ICHG_LOAD: assert property (
		ichg_valid && ichg_ok && !agf_fall && !pres_fall && !(init_q && vlim_valid && vlim_zero)
		|=> charge_current_setpoint_o == {$past(ichg_word[12:6]), 6'h00})
		else $error("Current word not taken as setpoint.");

	AST_ICHG_RSVD: assert property (
		ichg_valid && !ichg_ok && !agf_fall && !pres_fall && !vlim_valid
		|=> $stable(ichg_q))
		else $error("Current write with reserved bits changed the setpoint.");

	AST_ICHG_LO_ZERO: assert property (
		reg_rd_en_i && reg_addr_i == charge_setpoint_pkg::ADDR_ICHG_LO
		|=> reg_rdata_o[5:0] == 6'h00)
		else $error("Ignored low bits of current read nonzero.");

	AST_ICHG_POR: assert property (
		$rose(init_q) |-> ichg_q == 7'h00)
		else $error("Current setpoint not zero after reset.");

	AST_ADAPTER_CLEAR: assert property (
		agf_fall && !ov_s |=> ichg_q == 7'h00)
		else $error("Adapter loss did not clear current.");

	AST_REMOVAL_CLEAR: assert property (
		pres_fall |=> ichg_q == 7'h00)
		else $error("Battery removal did not clear current.");

	AST_PRECHG_CLAMP: assert property (
		pre_multi |=> current_limit_ma_o <= charge_setpoint_pkg::PRECHG_CLAMP_MA && regulate_min_sys_o)
		else $error("Multi-cell precharge current not clamped.");

	AST_LOWV_CLAMP: assert property (
		midv1 |=> current_limit_ma_o <= charge_setpoint_pkg::LOWV_CLAMP_MA && battery_switch_linear_o)
		else $error("Single-cell low-voltage clamp missing.");

	AST_VLIM_RANGE: assert property (
		init_q && vlim_valid && vlim_ok && !vlim_zero && !vlim_in_range |=> $stable(vlim_q))
		else $error("Out-of-range voltage write was taken.");

	AST_VLIM_LEGAL: assert property (
		init_q |-> vlim_q[2:0] == 3'h0 && vlim_q >= charge_setpoint_pkg::VLIM_MIN_MV &&
			vlim_q <= charge_setpoint_pkg::VLIM_MAX_MV)
		else $error("Charge voltage outside legal window.");

	AST_VLIM_POR: assert property (
		$rose(init_q) |-> vlim_q == charge_setpoint_pkg::cell_default_mv(cells_q))
		else $error("Charge voltage default wrong after reset.");

	AST_VLIM_ZERO: assert property (
		init_q && vlim_valid && vlim_zero |=>
			vlim_q == charge_setpoint_pkg::cell_default_mv(cells_q) && ichg_q == 7'h00)
		else $error("Zero voltage write did not restore default.");

	AST_ENABLE: assert property (
		agf_s && ichg_q != 7'h00 ##1 agf_s && ichg_q != 7'h00 |-> charge_enable_o)
		else $error("Charging not enabled with current and adapter.");

endmodule // charge_setpoint_registers
`default_nettype wire

/* File: charge_setpoint_pkg.sv */
// Purpose: Shared constants for the charge setpoint register bank.
// Assumes: Byte addresses come from the serial-port logic on the same clock.
// Notes:   Voltages are in mV and currents in mA, both as plain binary.
package charge_setpoint_pkg;

	// Byte addresses of the register pairs and of the option byte.
	localparam logic [7:0] ADDR_OPTION  = 8'h00;
	localparam logic [7:0] ADDR_ICHG_LO = 8'h02;
	localparam logic [7:0] ADDR_ICHG_HI = 8'h03;
	localparam logic [7:0] ADDR_VLIM_LO = 8'h04;
	localparam logic [7:0] ADDR_VLIM_HI = 8'h05;

	// Option byte: bit that keeps the battery switch linear in precharge.
	localparam int   LINEAR_BIT = 2;
	localparam logic LINEAR_RST = 1'b1;

	// Charge-current field layout; one field count is 64 mA.
	localparam logic [7:0] ICHG_HI_RSVD  = 8'he0;
	localparam int         ICHG_LO_SHIFT = 6;
	localparam logic [6:0] ICHG_RST      = 7'h00;

	// Charge-voltage field layout and legal window (1024 to 19200 mV).
	localparam logic [15:0] VLIM_RSVD_HI = 16'h8000;
	localparam logic [15:0] VLIM_FIELD   = 16'h7ff8;
	localparam logic [15:0] VLIM_MIN_MV  = 16'h0400;
	localparam logic [15:0] VLIM_MAX_MV  = 16'h4b00;
	localparam logic [15:0] VLIM_RST     = 16'h0000;

	// Per-cell-count defaults: 4200, 8400, 12600 and 16800 mV.
	localparam logic [15:0] VDEF_1S = 16'h1068;
	localparam logic [15:0] VDEF_2S = 16'h20d0;
	localparam logic [15:0] VDEF_3S = 16'h3138;
	localparam logic [15:0] VDEF_4S = 16'h41a0;
	localparam logic [1:0]  CELL_1S = 2'h0;

	// Clamp levels: 384 mA and 2048 mA; single-cell thresholds 3000 and 3600 mV.
	localparam logic [12:0] PRECHG_CLAMP_MA = 13'h0180;
	localparam logic [12:0] LOWV_CLAMP_MA   = 13'h0800;
	localparam logic [15:0] FAST_ENTRY_MV   = 16'h0bb8;
	localparam logic [15:0] LDO_EXIT_MV     = 16'h0e10;

	// Default charge voltage for a cell-count code (0 means one cell).
	function automatic logic [15:0] cell_default_mv(input logic [1:0] cells);
		unique case (cells)
			2'h0: cell_default_mv = VDEF_1S;
			2'h1: cell_default_mv = VDEF_2S;
			2'h2: cell_default_mv = VDEF_3S;
			2'h3: cell_default_mv = VDEF_4S;
		endcase
	endfunction

endpackage

/* File: level_sync.sv */
// Purpose: Two-flop synchroniser for slow pin levels.
// Assumes: Inputs are levels that stay put for several clock cycles.
// Notes:   No reset, so the pin level is valid two edges into reset.
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys_i,
	input  wire logic [W-1:0] async_i,
	output var  logic [W-1:0] sync_o
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] stab_q;
	logic [W-1:0] stab_d;

	// The first stage feeds only the second stage.
	always_comb begin
		meta_d = async_i;
		stab_d = meta_q;
	end

	// Left without reset so a strap level is already settled at release.
	always_ff @(posedge clk_sys_i) begin
		meta_q <= meta_d;
		stab_q <= stab_d;
	end

	assign sync_o = stab_q;

endmodule // level_sync
`default_nettype wire

/* File: byte_pair_latch.sv */
// Purpose: Joins a low-byte and a high-byte write into one 16-bit word.
// Assumes: The host writes the low byte first, then the high byte.
// Notes:   A high byte with no low byte pending is dropped.
`timescale 1ns/100ps
`default_nettype none
module byte_pair_latch (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_n_i,
	input  wire logic        lo_wr_i,
	input  wire logic        hi_wr_i,
	input  wire logic [7:0]  wdata_i,
	output var  logic [15:0] word_o,
	output var  logic        word_valid_o
);

	logic        pend_q;
	logic        pend_d;
	logic [7:0]  lo_q;
	logic [7:0]  lo_d;
	logic [15:0] word_q;
	logic [15:0] word_d;
	logic        valid_q;
	logic        valid_d;

	// Hold the low byte until its partner arrives, then emit one pulse.
	always_comb begin
		pend_d  = pend_q;
		lo_d    = lo_q;
		word_d  = word_q;
		valid_d = 1'b0;
		if (lo_wr_i) begin
			pend_d = 1'b1;
			lo_d   = wdata_i;
		end else if (hi_wr_i && pend_q) begin
			pend_d  = 1'b0;
			word_d  = {wdata_i, lo_q};
			valid_d = 1'b1;
		end
	end

	// State registers.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pend_q  <= 1'b0;
			lo_q    <= 8'h00;
			word_q  <= 16'h0000;
			valid_q <= 1'b0;
		end else begin
			pend_q  <= pend_d;
			lo_q    <= lo_d;
			word_q  <= word_d;
			valid_q <= valid_d;
		end
	end

	assign word_o       = word_q;
	assign word_valid_o = valid_q;

endmodule // byte_pair_latch
`default_nettype wire

/* File: host_ec_model.sv */
// Purpose: Host controller model that writes and reads setpoint bytes.
// Assumes: The bench calls its tasks; strobes change on the falling edge.
// Notes:   A released address or data bus shows the inverse of its last value.
`timescale 1ns/100ps
`default_nettype none
module host_ec_model (
	input  wire logic       clk_sys_i,
	input  wire logic [7:0] reg_rdata_i,
	output var  logic       reg_wr_en_o,
	output var  logic       reg_rd_en_o,
	output var  logic [7:0] reg_addr_o,
	output var  logic [7:0] reg_wdata_o
);
	// Idle bus at time zero.
	initial begin
		reg_wr_en_o = 1'b0;
		reg_rd_en_o = 1'b0;
		reg_addr_o  = 8'h00;
		reg_wdata_o = 8'h00;
	end

	// One byte strobe, held over exactly one rising edge.
	task automatic put_byte(input logic [7:0] addr, input logic [7:0] data, input logic rd);
		@(negedge clk_sys_i);
		reg_wr_en_o = ~rd;
		reg_rd_en_o = rd;
		reg_addr_o  = addr;
		reg_wdata_o = data;
	endtask

	// Inverting the idle bus keeps a stale value from passing for a valid one.
	task automatic release_bus();
		@(negedge clk_sys_i);
		reg_wr_en_o = 1'b0;
		reg_rd_en_o = 1'b0;
		reg_addr_o  = ~reg_addr_o;
		reg_wdata_o = ~reg_wdata_o;
	endtask

	// Low byte then high byte, back to back, so the pair forms one word.
	task automatic write_word(input logic [7:0] lo_addr, input logic [15:0] word);
		put_byte(lo_addr, word[7:0], 1'b0);
		put_byte(lo_addr + 8'h01, word[15:8], 1'b0);
		release_bus();
	endtask

	// Read data is taken two edges after the strobe, where it stands.
	task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
		put_byte(addr, 8'h00, 1'b1);
		release_bus();
		@(negedge clk_sys_i);
		data = reg_rdata_i;
	endtask

	// Voltage goes first, since the current write is what starts charging.
	task automatic program_charge(input logic [15:0] mv, input logic [15:0] ichg);
		write_word(charge_setpoint_pkg::ADDR_VLIM_LO, mv);
		write_word(charge_setpoint_pkg::ADDR_ICHG_LO, ichg & 16'h1fff);
	endtask
endmodule // host_ec_model
`default_nettype wire

/* File: charge_setpoint_registers_test.sv */
// Purpose: Self-checking bench for the charge setpoint register bank.
// Assumes: The host model drives byte strobes on falling edges.
// Notes:   Settle waits cover the two-edge write path and the pin syncs.
`timescale 1ns/100ps
`default_nettype none
module charge_setpoint_registers_test;
	logic        clk_sys_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        adapter_good_flag = 1'b1;
	logic        input_overvoltage = 1'b0;
	logic        presence_pin = 1'b1;
	logic [1:0]  cell_sel = 2'h0;
	logic        precharge = 1'b0;
	logic [15:0] battery_mv = 16'h1000;
	logic [12:0] ichg;
	logic [15:0] vlim;
	logic        en;
	logic [12:0] lim;
	logic        lin;
	logic        rmin;
	int          error_cnt = 0;
	int          n_compared = 0;

	// The clock toggles every half period of 2.5 ns.
	always #2.5 clk_sys_i = ~clk_sys_i;

	charge_setpoint_registers u_dut (
		.clk_sys_i                (clk_sys_i),
		.rst_n_i                  (rst_n_i),
		.reg_wr_en_i              (wr_en),
		.reg_rd_en_i              (rd_en),
		.reg_addr_i               (addr),
		.reg_wdata_i              (wdata),
		.reg_rdata_o              (rdata),
		.adapter_good_flag_i      (adapter_good_flag),
		.input_overvoltage_i      (input_overvoltage),
		.cell_count_presence_pin_i(presence_pin),
		.cell_count_sel_i         (cell_sel),
		.precharge_i              (precharge),
		.battery_mv_i             (battery_mv),
		.charge_current_setpoint_o(ichg),
		.charge_voltage_limit_o   (vlim),
		.charge_enable_o          (en),
		.current_limit_ma_o       (lim),
		.battery_switch_linear_o  (lin),
		.regulate_min_sys_o       (rmin)
	);

	host_ec_model u_host (
		.clk_sys_i  (clk_sys_i),
		.reg_rdata_i(rdata),
		.reg_wr_en_o(wr_en),
		.reg_rd_en_o(rd_en),
		.reg_addr_o (addr),
		.reg_wdata_o(wdata)
	);

	// Every compare is counted; a mismatch is reported on the spot.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Single exit point of the run.
	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Waits a fixed number of falling edges.
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask

	// Reset is held three cycles so the unreset pin syncs fill first.
	task automatic do_reset(input logic [1:0] cells);
		@(negedge clk_sys_i);
		rst_n_i = 1'b0;
		cell_sel = cells;
		wait_cyc(3);
		rst_n_i = 1'b1;
		wait_cyc(3);
	endtask

	// A word write followed by enough cycles for the setpoint to land.
	task automatic wr(input logic [7:0] lo_addr, input logic [15:0] word);
		u_host.write_word(lo_addr, word);
		wait_cyc(4);
	endtask

	// A lone byte write, used to probe how half words are handled.
	task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
		u_host.put_byte(a, d, 1'b0);
		u_host.release_bus();
		wait_cyc(4);
	endtask

	// Watchdog: a hang counts as a mismatch and closes the run.
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		error_cnt++;
		end_of_test();
	end

	// Main sequence of scenarios.
	initial begin
		logic [7:0]  rd;
		automatic logic [15:0] vdef [4] = '{16'h1068, 16'h20d0, 16'h3138, 16'h41a0};
		automatic logic [15:0] iw [3] = '{16'h1fc0, 16'h007f, 16'h0fff};
		automatic logic [12:0] ie [3] = '{13'h1fc0, 13'h0040, 13'h0fc0};
		automatic logic [15:0] vw [6] = '{16'h03f8, 16'h0400, 16'h4b08, 16'h4b00,
			16'h1237, 16'h8400};
		automatic logic [15:0] ve [6] = '{16'h41a0, 16'h0400, 16'h0400, 16'h4b00,
			16'h1230, 16'h1230};
		automatic logic [15:0] bm [3] = '{16'h0bb7, 16'h0bb8, 16'h0e10};
		automatic logic [12:0] bl [3] = '{13'h0180, 13'h0800, 13'h1000};
		for (int c = 0; c < 4; c++) begin
			do_reset(2'(c));
			check(16'(ichg), 16'h0000);
			check(vlim, vdef[c]);
		end
		u_host.read_byte(charge_setpoint_pkg::ADDR_OPTION, rd);
		check(16'(rd), 16'h0004);
		wr(charge_setpoint_pkg::ADDR_ICHG_LO, 16'h1000);
		check(16'(ichg), 16'h1000);
		check(vlim, 16'h41a0);
		check(16'(en), 16'h0001);
		precharge = 1'b1;
		wait_cyc(4);
		check(16'(lim), 16'h0180);
		check(16'(rmin), 16'h0001);
		check(16'(lin), 16'h0001);
		wr_byte(charge_setpoint_pkg::ADDR_OPTION, 8'h00);
		check(16'(lin), 16'h0000);
		precharge = 1'b0;
		// Field weights, ignored low bits and readback of the high byte.
		for (int i = 0; i < 3; i++) begin
			wr(charge_setpoint_pkg::ADDR_ICHG_LO, iw[i]);
			check(16'(ichg), 16'(ie[i]));
			u_host.read_byte(charge_setpoint_pkg::ADDR_ICHG_HI, rd);
			check(16'(rd), 16'(ie[i][12:8]));
			// The low byte reads back only the two field bits; the rest stay zero.
			u_host.read_byte(charge_setpoint_pkg::ADDR_ICHG_LO, rd);
			check(16'(rd), 16'(ie[i][7:0]));
		end
		for (int b = 13; b < 16; b++) begin
			wr(charge_setpoint_pkg::ADDR_ICHG_LO, 16'h0040 | (16'h0001 << b));
			check(16'(ichg), 16'h0fc0);
		end
		// A lone low byte waits for its partner; a high byte with no low byte pending is dropped.
		wr_byte(charge_setpoint_pkg::ADDR_ICHG_LO, 8'h80);
		check(16'(ichg), 16'h0fc0);
		wr_byte(charge_setpoint_pkg::ADDR_ICHG_HI, 8'h00);
		check(16'(ichg), 16'h0080);
		wr_byte(charge_setpoint_pkg::ADDR_ICHG_HI, 8'h01);
		check(16'(ichg), 16'h0080);
		for (int i = 0; i < 6; i++) begin
			wr(charge_setpoint_pkg::ADDR_VLIM_LO, vw[i]);
			check(vlim, ve[i]);
			u_host.read_byte(charge_setpoint_pkg::ADDR_VLIM_LO, rd);
			check(16'(rd), 16'(ve[i][7:0]));
		end
		wr(charge_setpoint_pkg::ADDR_VLIM_LO, 16'h0000);
		check(vlim, 16'h41a0);
		check(16'(ichg), 16'h0000);
		check(16'(en), 16'h0000);
		u_host.program_charge(16'h3340, 16'h1000);
		wait_cyc(4);
		check(vlim, 16'h3340);
		// Adapter loss during input overvoltage keeps the setpoint.
		input_overvoltage = 1'b1;
		adapter_good_flag = 1'b0;
		wait_cyc(8);
		check(16'(ichg), 16'h1000);
		adapter_good_flag = 1'b1;
		input_overvoltage = 1'b0;
		wait_cyc(8);
		adapter_good_flag = 1'b0;
		wait_cyc(8);
		check(16'(ichg), 16'h0000);
		adapter_good_flag = 1'b1;
		wr(charge_setpoint_pkg::ADDR_ICHG_LO, 16'h1000);
		presence_pin = 1'b0;
		wait_cyc(8);
		check(16'(ichg), 16'h0000);
		presence_pin = 1'b1;
		// Single cell: clamps across the two battery thresholds.
		do_reset(2'h0);
		wr(charge_setpoint_pkg::ADDR_ICHG_LO, 16'h1000);
		for (int i = 0; i < 3; i++) begin
			battery_mv = bm[i];
			wait_cyc(4);
			check(16'(lim), 16'(bl[i]));
			if (i == 1) begin
				check(16'(lin), 16'h0001);
			end
		end
		end_of_test();
	end
endmodule // charge_setpoint_registers_test
`default_nettype wire
